/* File: src/vmc_pkg.sv */
// Shared constants and types of the video mode configuration bank
package vmc_pkg;

    // Clock and detector settle time
    localparam int CLK_PERIOD_NS  = 50;
    localparam int AFD_SETTLE_NS  = 2000;
    localparam int AFD_SETTLE_CYC = (AFD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // APB byte offsets
    localparam logic [11:0] OFS_FMT_CTRL    = 12'h000;
    localparam logic [11:0] OFS_CHROMA_CTRL = 12'h004;
    localparam logic [11:0] OFS_STATUS      = 12'h008;

    // Format select control fields
    localparam int FMT_VARA_BIT   = 7;
    localparam int FMT_VARB_BIT   = 6;
    localparam int FMT_ACFG_BIT   = 5;
    localparam int FMT_SQUARE_BIT = 4;
    localparam int FMT_FIELD_LSB  = 0;

    // Chroma and input control fields
    localparam int CHR_WCRUSH_BIT = 7;
    localparam int CHR_GAIN_BIT   = 6;
    localparam int CHR_KILL_BIT   = 5;
    localparam int CHR_AUTO_BIT   = 4;
    localparam int CHR_MANF_BIT   = 3;
    localparam int CHR_INPUT_LSB  = 1;
    localparam int CHR_REACQ_BIT  = 0;

    // Reset values
    localparam logic [7:0] FMT_CTRL_RST    = 8'h00;
    localparam logic [7:0] CHROMA_CTRL_RST = 8'hF0;

    // Autoconfiguration target window
    localparam logic [11:0] ACFG_FIRST_ADDR = 12'h470;
    localparam logic [11:0] ACFG_LAST_ADDR  = 12'h47F;
    localparam logic [3:0]  ACFG_LAST_IDX   = 4'hF;

    // Video formats
    typedef enum logic [3:0] {
        FMT_AUTO      = 4'h0,
        FMT_NTSC_M    = 4'h1,
        FMT_NTSC_J    = 4'h2,
        FMT_NTSC_443  = 4'h3,
        FMT_PAL_BDGHI = 4'h4,
        FMT_PAL_M     = 4'h5,
        FMT_PAL_N     = 4'h6,
        FMT_PAL_NC    = 4'h7,
        FMT_PAL_60    = 4'h8,
        FMT_SECAM     = 4'hC
    } vmc_fmt_t;

    // Input signal formats
    typedef enum logic [1:0] {
        IN_COMPOSITE = 2'b00,
        IN_LUMA_CHR  = 2'b01,
        IN_LUMA_HALF = 2'b10,
        IN_COMPONENT = 2'b11
    } vmc_input_t;

    // Measurements from the decoder front end
    typedef struct packed {
        logic valid;
        logic secam;
        logic lines625;
        logic sc443;
        logic phase_alt;
    } vmc_det_t;

    // True for auto and every defined format code
    function automatic logic vmc_fmt_known(input logic [3:0] code);
        return (code <= 4'h8) || (code == 4'hC);
    endfunction

endpackage

/* File: src/vmc_afd_fsm.sv */
// Auto format detection state machine
`timescale 1ns/1ps
module vmc_afd_fsm
    import vmc_pkg::*;
#(
    parameter int SETTLE_CYC = AFD_SETTLE_CYC
)(
    // Clock and reset
    input  wire logic     clk_i,
    input  wire logic     rst_n_i,
    // Controls
    input  wire logic     acquire_i,
    input  wire logic     var_a_i,
    input  wire logic     var_b_i,
    input  wire vmc_det_t det_i,
    // Result
    output vmc_fmt_t      fmt_o,
    output logic          locked_o
);
    localparam int CNT_W = $clog2(SETTLE_CYC + 1);

    typedef enum logic [1:0] {
        ST_INIT   = 2'b00,
        ST_SEARCH = 2'b01,
        ST_LOCKED = 2'b10
    } vmc_afd_st_t;

    if (SETTLE_CYC < 1) begin : g_chk
        $error("SETTLE_CYC must be at least 1");
    end

    vmc_afd_st_t      state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    vmc_fmt_t         cand, cand_q, fmt_d;
    logic             locked_d;

    // Map measurements to a format, variants chosen by software
    function automatic vmc_fmt_t classify(input vmc_det_t d, input logic va, input logic vb);
        if (d.secam)
            return FMT_SECAM;
        if (d.lines625)
            return d.sc443 ? (vb ? FMT_PAL_N : FMT_PAL_BDGHI) : FMT_PAL_NC;
        if (d.sc443)
            return d.phase_alt ? FMT_PAL_60 : FMT_NTSC_443;
        if (d.phase_alt)
            return FMT_PAL_M;
        return va ? FMT_NTSC_J : FMT_NTSC_M;
    endfunction

    // Next state; a held acquire overrides the state and the counter
    always_comb begin
        cand     = classify(det_i, var_a_i, var_b_i);
        state_d  = state_q;
        cnt_d    = cnt_q;
        fmt_d    = fmt_o;
        case (state_q)
            ST_INIT: begin
                cnt_d = '0;
                state_d = ST_SEARCH;
            end
            ST_SEARCH: begin
                if (!det_i.valid || cand != cand_q) begin
                    cnt_d = '0;
                end else if (cnt_q == CNT_W'(SETTLE_CYC - 1)) begin
                    state_d = ST_LOCKED;
                    fmt_d   = cand;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ST_LOCKED: begin
                if (!det_i.valid) begin
                    state_d = ST_SEARCH;
                    cnt_d   = '0;
                end
            end
            default: state_d = ST_INIT;
        endcase
        if (acquire_i) begin
            state_d = ST_INIT;
            cnt_d   = '0;
        end
        locked_d = (state_d == ST_LOCKED);
    end

    // State registers; status keeps the last result until a new lock
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q  <= ST_INIT;
            cnt_q    <= '0;
            cand_q   <= FMT_AUTO;
            fmt_o    <= FMT_AUTO;
            locked_o <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            cand_q   <= cand;
            fmt_o    <= fmt_d;
            locked_o <= locked_d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_rerun;
        acquire_i ##1 !acquire_i;
    endsequence

    property p_acq_init;
        acquire_i |=> state_q == ST_INIT && !locked_o;
    endproperty
    a_acq_init: assert property (p_acq_init) else $error("acquire did not hold init");

    property p_rerun;
        s_rerun |-> !locked_o ##1 state_q == ST_SEARCH;
    endproperty
    a_rerun: assert property (p_rerun) else $error("detection not rerun");

    property p_lock;
        state_q == ST_SEARCH && det_i.valid && cand == cand_q && !acquire_i
            && cnt_q == CNT_W'(SETTLE_CYC - 1) |=> locked_o && fmt_o == $past(cand);
    endproperty
    a_lock: assert property (p_lock) else $error("lock status not updated");

    property p_var_a;
        state_q != ST_LOCKED && state_d == ST_LOCKED && !det_i.secam && !det_i.lines625
            && !det_i.sc443 && !det_i.phase_alt
            |=> fmt_o == ($past(var_a_i) ? FMT_NTSC_J : FMT_NTSC_M);
    endproperty
    a_var_a: assert property (p_var_a) else $error("wrong 525 line variant");

    property p_var_b;
        state_q != ST_LOCKED && state_d == ST_LOCKED && !det_i.secam && det_i.lines625
            && det_i.sc443 |=> fmt_o == ($past(var_b_i) ? FMT_PAL_N : FMT_PAL_BDGHI);
    endproperty
    a_var_b: assert property (p_var_b) else $error("wrong 625 line variant");

endmodule

/* File: src/vmc_fmt_resolve.sv */
// Resolves the active format and subcarrier lock speed
`timescale 1ns/1ps
module vmc_fmt_resolve
    import vmc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Controls
    input  wire logic [3:0] manual_i,
    input  wire vmc_fmt_t   det_fmt_i,
    input  wire logic       auto_lock_i,
    input  wire logic       man_fast_i,
    input  wire logic       sc_locked_i,
    // Results
    output logic [3:0]      active_o,
    output logic            fast_o,
    output logic            reserved_o
);
    logic [3:0] active_d;
    logic       fast_d;
    logic       reserved_d;

    // Reserved codes fall back to detection instead of an undefined format
    always_comb begin
        reserved_d = !vmc_fmt_known(manual_i);
        if (manual_i != 4'h0 && !reserved_d)
            active_d = manual_i;
        else
            active_d = det_fmt_i;
        fast_d = auto_lock_i ? !sc_locked_i : man_fast_i;
    end

    // Result registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_o   <= 4'h0;
            fast_o     <= 1'b1;
            reserved_o <= 1'b0;
        end else begin
            active_o   <= active_d;
            fast_o     <= fast_d;
            reserved_o <= reserved_d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_manual;
        manual_i != 4'h0 && vmc_fmt_known(manual_i) |=> active_o == $past(manual_i);
    endproperty
    a_manual: assert property (p_manual) else $error("manual format not forced");

    property p_reserved;
        manual_i == 4'h0 || !vmc_fmt_known(manual_i) |=> active_o == $past(det_fmt_i);
    endproperty
    a_reserved: assert property (p_reserved) else $error("no fall back to detection");

    property p_auto_lock;
        auto_lock_i |=> fast_o == !$past(sc_locked_i);
    endproperty
    a_auto_lock: assert property (p_auto_lock) else $error("auto lock speed wrong");

    property p_man_lock;
        !auto_lock_i |=> fast_o == $past(man_fast_i);
    endproperty
    a_man_lock: assert property (p_man_lock) else $error("manual lock speed wrong");

endmodule

/* File: src/vmc_top.sv */
// APB register bank and control outputs for the video mode configuration
`timescale 1ns/1ps
module vmc_top
    import vmc_pkg::*;
#(
    parameter int SETTLE_CYC = AFD_SETTLE_CYC
)(
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        ARST_N_I,
    // APB slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [3:0]  PSTRB_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // Measurements from the decoder front end
    input  wire logic        DET_VALID_I,
    input  wire logic        DET_SECAM_I,
    input  wire logic        DET_LINES625_I,
    input  wire logic        DET_SC443_I,
    input  wire logic        DET_PHASE_ALT_I,
    input  wire logic        SC_LOCKED_I,
    // Decoder controls and status
    output logic      [3:0]  ACTIVE_FORMAT_O,
    output logic      [3:0]  DETECTED_FORMAT_O,
    output logic             AFD_LOCKED_O,
    output logic             SQUARE_SAMPLING_O,
    output logic             WHITE_CRUSH_EN_O,
    output logic             CHROMA_GAIN_EN_O,
    output logic             COLOR_KILLER_EN_O,
    output logic             SC_FAST_LOCK_O,
    output logic      [1:0]  INPUT_FORMAT_O,
    // Autoconfiguration load port
    output logic             AUTOCFG_LOAD_O,
    output logic      [11:0] AUTOCFG_ADDR_O,
    output logic      [3:0]  AUTOCFG_FMT_O
);
    logic [7:0]  fmt_q, fmt_d;
    logic [7:0]  chroma_q, chroma_d;
    logic        ready_q, ready_d;
    logic        slverr_q, slverr_d;
    logic [31:0] rdata_q, rdata_d;
    logic        access;
    logic        complete;
    logic        mapped;
    logic        wr_en;
    logic [31:0] rd_val;
    logic        fmt_seen_q, fmt_seen_d;
    logic        chr_seen_q, chr_seen_d;
    vmc_det_t    det;
    vmc_fmt_t    det_fmt;
    logic        afd_locked;
    logic [3:0]  active_fmt;
    logic        fast_lock;
    logic        fmt_reserved;
    logic        acfg_busy_q, acfg_busy_d;
    logic        acfg_valid_q, acfg_valid_d;
    logic [3:0]  acfg_idx_q, acfg_idx_d;
    logic [3:0]  acfg_fmt_q, acfg_fmt_d;
    logic        acfg_load_q, acfg_load_d;
    logic [11:0] acfg_addr_q, acfg_addr_d;
    logic        autoconfig_disable;

    // Measurements share this clock, so no synchroniser is needed
    assign det = '{
        valid:     DET_VALID_I,
        secam:     DET_SECAM_I,
        lines625:  DET_LINES625_I,
        sc443:     DET_SC443_I,
        phase_alt: DET_PHASE_ALT_I
    };

    // Auto format detection, restarted by the reacquire bit
    vmc_afd_fsm #(
        .SETTLE_CYC (SETTLE_CYC)
    ) u_afd (
        .clk_i     (CLK_I),
        .rst_n_i   (ARST_N_I),
        .acquire_i (chroma_q[CHR_REACQ_BIT]),
        .var_a_i   (fmt_q[FMT_VARA_BIT]),
        .var_b_i   (fmt_q[FMT_VARB_BIT]),
        .det_i     (det),
        .fmt_o     (det_fmt),
        .locked_o  (afd_locked)
    );

    // Manual override and lock speed selection
    vmc_fmt_resolve u_resolve (
        .clk_i       (CLK_I),
        .rst_n_i     (ARST_N_I),
        .manual_i    (fmt_q[FMT_FIELD_LSB +: 4]),
        .det_fmt_i   (det_fmt),
        .auto_lock_i (chroma_q[CHR_AUTO_BIT]),
        .man_fast_i  (chroma_q[CHR_MANF_BIT]),
        .sc_locked_i (SC_LOCKED_I),
        .active_o    (active_fmt),
        .fast_o      (fast_lock),
        .reserved_o  (fmt_reserved)
    );

    // APB decode; the access phase always takes two cycles
    always_comb begin
        access   = PSEL_I && PENABLE_I;
        complete = access && ready_q;
        mapped   = (PADDR_I == OFS_FMT_CTRL) || (PADDR_I == OFS_CHROMA_CTRL)
                   || (PADDR_I == OFS_STATUS);
        wr_en    = complete && PWRITE_I && PSTRB_I[0];
        case (PADDR_I)
            OFS_FMT_CTRL:    rd_val = {24'h000000, fmt_q};
            OFS_CHROMA_CTRL: rd_val = {24'h000000, chroma_q};
            OFS_STATUS: begin
                rd_val = {20'h00000, acfg_busy_q, fmt_reserved, fast_lock, afd_locked,
                          active_fmt, det_fmt};
            end
            default:         rd_val = 32'h00000000;
        endcase
    end

    // Bus answer; data and error are only meaningful with ready
    always_comb begin
        ready_d  = access && !ready_q;
        rdata_d  = 32'h00000000;
        slverr_d = 1'b0;
        if (ready_d) begin
            slverr_d = !mapped;
            if (!PWRITE_I)
                rdata_d = rd_val;
        end
    end

    // Bus answer registers
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ready_q  <= 1'b0;
            rdata_q  <= 32'h00000000;
            slverr_q <= 1'b0;
        end else begin
            ready_q  <= ready_d;
            rdata_q  <= rdata_d;
            slverr_q <= slverr_d;
        end
    end

    // Control registers; writes land only at the edge that completes
    always_comb begin
        fmt_d      = fmt_q;
        chroma_d   = chroma_q;
        fmt_seen_d = fmt_seen_q;
        chr_seen_d = chr_seen_q;
        if (wr_en && PADDR_I == OFS_FMT_CTRL) begin
            fmt_d      = PWDATA_I[7:0];
            fmt_seen_d = 1'b1;
        end
        if (wr_en && PADDR_I == OFS_CHROMA_CTRL) begin
            chroma_d   = PWDATA_I[7:0];
            chr_seen_d = 1'b1;
        end
    end

    // Control register storage
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            fmt_q      <= FMT_CTRL_RST;
            chroma_q   <= CHROMA_CTRL_RST;
            fmt_seen_q <= 1'b0;
            chr_seen_q <= 1'b0;
        end else begin
            fmt_q      <= fmt_d;
            chroma_q   <= chroma_d;
            fmt_seen_q <= fmt_seen_d;
            chr_seen_q <= chr_seen_d;
        end
    end

    // Autoconfig sweep; an abort forces a full reload once re-enabled
    always_comb begin
        autoconfig_disable     = fmt_q[FMT_ACFG_BIT];
        acfg_busy_d  = acfg_busy_q;
        acfg_valid_d = acfg_valid_q;
        acfg_idx_d   = acfg_idx_q;
        acfg_fmt_d   = acfg_fmt_q;
        acfg_load_d  = 1'b0;
        acfg_addr_d  = acfg_addr_q;
        if (autoconfig_disable) begin
            acfg_busy_d  = 1'b0;
            acfg_valid_d = acfg_valid_q && !acfg_busy_q;
        end else if (acfg_busy_q) begin
            acfg_load_d = 1'b1;
            acfg_addr_d = ACFG_FIRST_ADDR + {8'h00, acfg_idx_q};
            acfg_idx_d  = acfg_idx_q + 4'h1;
            if (acfg_idx_q == ACFG_LAST_IDX)
                acfg_busy_d = 1'b0;
        end else if (!acfg_valid_q || active_fmt != acfg_fmt_q) begin
            acfg_busy_d  = 1'b1;
            acfg_valid_d = 1'b1;
            acfg_idx_d   = 4'h0;
            acfg_fmt_d   = active_fmt;
        end
    end

    // Autoconfig registers
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            acfg_busy_q  <= 1'b0;
            acfg_valid_q <= 1'b0;
            acfg_idx_q   <= 4'h0;
            acfg_fmt_q   <= 4'h0;
            acfg_load_q  <= 1'b0;
            acfg_addr_q  <= ACFG_FIRST_ADDR;
        end else begin
            acfg_busy_q  <= acfg_busy_d;
            acfg_valid_q <= acfg_valid_d;
            acfg_idx_q   <= acfg_idx_d;
            acfg_fmt_q   <= acfg_fmt_d;
            acfg_load_q  <= acfg_load_d;
            acfg_addr_q  <= acfg_addr_d;
        end
    end

    // Outputs taken straight from flip-flops
    assign PRDATA_O          = rdata_q;
    assign PREADY_O          = ready_q;
    assign PSLVERR_O         = slverr_q;
    assign ACTIVE_FORMAT_O   = active_fmt;
    assign DETECTED_FORMAT_O = det_fmt;
    assign AFD_LOCKED_O      = afd_locked;
    assign SQUARE_SAMPLING_O = fmt_q[FMT_SQUARE_BIT];
    assign WHITE_CRUSH_EN_O  = chroma_q[CHR_WCRUSH_BIT];
    assign CHROMA_GAIN_EN_O  = chroma_q[CHR_GAIN_BIT];
    assign COLOR_KILLER_EN_O = chroma_q[CHR_KILL_BIT];
    assign SC_FAST_LOCK_O    = fast_lock;
    assign INPUT_FORMAT_O    = chroma_q[CHR_INPUT_LSB +: 2];
    assign AUTOCFG_LOAD_O    = acfg_load_q;
    assign AUTOCFG_ADDR_O    = acfg_addr_q;
    assign AUTOCFG_FMT_O     = acfg_fmt_q;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);

    sequence s_wr_chroma;
        complete && PWRITE_I && PSTRB_I[0] && PADDR_I == OFS_CHROMA_CTRL;
    endsequence

    sequence s_wr_fmt;
        complete && PWRITE_I && PSTRB_I[0] && PADDR_I == OFS_FMT_CTRL;
    endsequence

    property p_fmt_rst;
        !fmt_seen_q |-> fmt_q == FMT_CTRL_RST && !SQUARE_SAMPLING_O;
    endproperty
    a_fmt_rst: assert property (p_fmt_rst) else $error("format control reset wrong");

    property p_chr_rst;
        !chr_seen_q |-> CHROMA_GAIN_EN_O && COLOR_KILLER_EN_O && WHITE_CRUSH_EN_O
            && INPUT_FORMAT_O == IN_COMPOSITE;
    endproperty
    a_chr_rst: assert property (p_chr_rst) else $error("chroma control reset wrong");

    property p_chr_wr;
        s_wr_chroma |=> CHROMA_GAIN_EN_O == $past(PWDATA_I[CHR_GAIN_BIT])
            && COLOR_KILLER_EN_O == $past(PWDATA_I[CHR_KILL_BIT]);
    endproperty
    a_chr_wr: assert property (p_chr_wr) else $error("chroma enables not written");

    property p_input_wr;
        s_wr_chroma |=> INPUT_FORMAT_O == $past(PWDATA_I[CHR_INPUT_LSB +: 2]);
    endproperty
    a_input_wr: assert property (p_input_wr) else $error("input format not written");

    property p_sq_wr;
        s_wr_fmt |=> SQUARE_SAMPLING_O == $past(PWDATA_I[FMT_SQUARE_BIT]);
    endproperty
    a_sq_wr: assert property (p_sq_wr) else $error("square sampling not written");

    property p_acfg_off;
        autoconfig_disable |=> !AUTOCFG_LOAD_O;
    endproperty
    a_acfg_off: assert property (p_acfg_off) else $error("autoconfig ran while off");

    property p_acfg_first;
        $rose(acfg_busy_q) && !autoconfig_disable |=> AUTOCFG_LOAD_O && AUTOCFG_ADDR_O == ACFG_FIRST_ADDR;
    endproperty
    a_acfg_first: assert property (p_acfg_first) else $error("sweep start wrong");

    property p_acfg_range;
        AUTOCFG_LOAD_O |-> AUTOCFG_ADDR_O >= ACFG_FIRST_ADDR && AUTOCFG_ADDR_O <= ACFG_LAST_ADDR;
    endproperty
    a_acfg_range: assert property (p_acfg_range) else $error("autoconfig out of range");

    property p_apb_wait;
        PSEL_I && !PENABLE_I ##1 PSEL_I && PENABLE_I |-> !PREADY_O ##1 PREADY_O;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("APB ready timing wrong");

endmodule

/* File: verification/test_vmc_top.sv */
// Self-checking bench of the video mode configuration register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module test_vmc_top;
    import vmc_pkg::*;
    // Bench signals
    logic        CLK_I, ARST_N_I, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, rdat;
    logic        rerr, d_val, d_sec, d_625, d_443, d_alt, sc_lk;
    logic [31:0] PRDATA_O;
    logic        PREADY_O, PSLVERR_O, AFD_LOCKED_O, SQ_O, WC_O, CG_O, CK_O, FAST_O, LOAD_O;
    logic [3:0]  ACTIVE_FORMAT_O, DETECTED_FORMAT_O, AFMT_O;
    logic [1:0]  INPUT_FORMAT_O;
    logic [11:0] AADDR_O, last_addr;
    logic [3:0]  det_exp, last_fmt;
    int          failures, n_tests, n_loads;
    vmc_top #(.SETTLE_CYC(3)) dut (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PSTRB_I(4'hF), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
        .DET_VALID_I(d_val), .DET_SECAM_I(d_sec), .DET_LINES625_I(d_625),
        .DET_SC443_I(d_443), .DET_PHASE_ALT_I(d_alt), .SC_LOCKED_I(sc_lk),
        .ACTIVE_FORMAT_O(ACTIVE_FORMAT_O), .DETECTED_FORMAT_O(DETECTED_FORMAT_O),
        .AFD_LOCKED_O(AFD_LOCKED_O), .SQUARE_SAMPLING_O(SQ_O), .WHITE_CRUSH_EN_O(WC_O),
        .CHROMA_GAIN_EN_O(CG_O), .COLOR_KILLER_EN_O(CK_O), .SC_FAST_LOCK_O(FAST_O),
        .INPUT_FORMAT_O(INPUT_FORMAT_O), .AUTOCFG_LOAD_O(LOAD_O),
        .AUTOCFG_ADDR_O(AADDR_O), .AUTOCFG_FMT_O(AFMT_O));
    // Free-running clock, 50 ns period
    initial begin
        CLK_I = 1'b0;
        forever #25 CLK_I = ~CLK_I;
    end
    // Counts autoconfig loads so scenarios can take differences
    always @(posedge CLK_I) begin
        if (LOAD_O === 1'b1) begin
            n_loads++;
            last_addr = AADDR_O;
            last_fmt  = AFMT_O;
        end
    end
    task complete_run;
        $display("mismatches %0d, comparisons %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge CLK_I);
    endtask
    // One APB transfer; request held until PREADY is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int i;
        @(posedge CLK_I);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge CLK_I);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge CLK_I);
            if (PREADY_O === 1'b1) break;
        end
        rdat = PRDATA_O;
        rerr = PSLVERR_O;
        psel <= 1'b0; penable <= 1'b0;
        if (i == 20) begin failures++; complete_run(); end
    endtask
    task t_reset;
        `CHK("crush", 1'b1, WC_O)
        `CHK("gain", 1'b1, CG_O)
        `CHK("killer", 1'b1, CK_O)
        `CHK("square", 1'b0, SQ_O)
        `CHK("input", 2'b00, INPUT_FORMAT_O)
        apb(1'b0, OFS_FMT_CTRL, 8'h00);
        `CHK("fmt reg", 32'h00, rdat)
        apb(1'b0, OFS_CHROMA_CTRL, 8'h00);
        `CHK("chroma reg", 32'hF0, rdat)
    endtask
    // Re-run detection for five classifications; acquire holds the detector idle
    task t_detect;
        int k, i;
        for (k = 0; k < 5; k++) begin
            apb(1'b1, OFS_FMT_CTRL, k == 0 ? 8'h80 : (k == 2 ? 8'h40 : 8'h00));
            d_val <= 1'b1; d_sec <= (k == 4); d_625 <= k[1]; d_443 <= k[1]; d_alt <= 1'b0;
            det_exp = k == 0 ? 4'h2 : (k == 1 ? 4'h1 : (k == 2 ? 4'h6 : (k == 3 ? 4'h4 : 4'hC)));
            apb(1'b1, OFS_CHROMA_CTRL, 8'hF1);
            cyc(6);
            `CHK("held unlocked", 1'b0, AFD_LOCKED_O)
            apb(1'b1, OFS_CHROMA_CTRL, 8'hF0);
            for (i = 0; i < 60 && AFD_LOCKED_O !== 1'b1; i++) @(posedge CLK_I);
            if (i == 60) begin failures++; complete_run(); end
            `CHK("detected", det_exp, DETECTED_FORMAT_O)
        end
    endtask
    // Every manual code: defined ones force, reserved ones fall back
    task t_manual;
        int k;
        for (k = 1; k < 16; k++) begin
            apb(1'b1, OFS_FMT_CTRL, k[7:0]);
            cyc(3);
            `CHK("active", (k <= 8 || k == 12) ? k[3:0] : det_exp, ACTIVE_FORMAT_O)
        end
        apb(1'b1, OFS_FMT_CTRL, 8'h10);
        cyc(3);
        `CHK("square", 1'b1, SQ_O)
        apb(1'b0, OFS_FMT_CTRL, 8'h00);
        `CHK("fmt readback", 32'h10, rdat)
    endtask
    task t_autocfg;
        int s;
        apb(1'b1, OFS_FMT_CTRL, 8'h21);
        cyc(2);
        s = n_loads;
        cyc(40);
        `CHK("loads off", 0, n_loads - s)
        apb(1'b1, OFS_FMT_CTRL, 8'h01);
        s = n_loads;
        cyc(40);
        `CHK("loads", 16, n_loads - s)
        `CHK("last addr", ACFG_LAST_ADDR, last_addr)
        `CHK("load fmt", 4'h1, last_fmt)
    endtask
    task t_chroma;
        int k;
        for (k = 0; k < 4; k++) begin
            apb(1'b1, OFS_CHROMA_CTRL, {5'h0, k[1:0], 1'b0});
            cyc(3);
            `CHK("input", k[1:0], INPUT_FORMAT_O)
            `CHK("gain off", 1'b0, CG_O)
            `CHK("killer off", 1'b0, CK_O)
            `CHK("crush off", 1'b0, WC_O)
        end
    endtask
    // Auto unlocked, auto locked, auto with manual bit, manual, manual off
    task t_lock;
        int k;
        for (k = 0; k < 5; k++) begin
            sc_lk <= (k >= 1 && k <= 3);
            apb(1'b1, OFS_CHROMA_CTRL, k < 2 ? 8'h10 : (k == 2 ? 8'h18 : (k == 3 ? 8'h08 : 8'h00)));
            cyc(3);
            `CHK("fast lock", (k == 0 || k == 3), FAST_O)
        end
    endtask
    task t_unmapped;
        apb(1'b0, 12'h00C, 8'h00);
        `CHK("slverr", 1'b1, rerr)
        `CHK("err data", 32'h0, rdat)
    endtask
    initial begin
        ARST_N_I = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
        pwdata = 32'h0; d_val = 1'b0; d_sec = 1'b0; d_625 = 1'b0; d_443 = 1'b0;
        d_alt = 1'b0; sc_lk = 1'b0; failures = 0; n_tests = 0; n_loads = 0;
        cyc(3);
        ARST_N_I <= 1'b1;
        t_reset();
        t_detect();
        t_manual();
        t_autocfg();
        t_chroma();
        t_lock();
        t_unmapped();
        complete_run();
    end
endmodule
